// [rtl/dcrp_core.sv]
// Cache policy and reservation conflict checker with AHB-Lite register slave
// Contract
// - Write-back write may complete before medium
// - Later commit error reported as deferred
// - Write with page-out-disable keeps cached blocks
// - Read with page-out-disable displaces no blocks
// - Forced write completes on medium first
// - Forced read fetched from medium
// - Both bits set bypass cache entirely
// - Verify commands flush then force medium
// - Lock pins blocks, unlock releases them
// - Prefetch loads range, stays replaceable
// - Synchronize commits range, reports errors
// - Other initiator's reservation gives conflict
// - Change definition conflicts unless per-initiator
// - Compare and copy checked as read/write
// - Format, rezero, start conflict on extent; prevent only with prevent bit set
// - Inquiry and request sense never conflict
// - Listed housekeeping commands ignore extents
// - Seek, lock, prefetch, sync checked normally
// - Mode select conflicts only when affecting
// - Diagnostics conflict only when affecting extent
// - Reassign refused inside foreign extent
// - Set limits conflicts on foreign extent
// - Block beyond capacity ends check condition
`timescale 1ns/1ps
module dcrp_core #(
  parameter logic [31:0] CAP_RESET = dcrp_pkg::CAP_RST
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  output dcrp_pkg::dcrp_med_t     med_req,
  input  wire logic               med_done,
  input  wire logic               med_err,
  input  wire logic               commit_err
);
  import dcrp_pkg::*;

  // ****************************************
  // State
  // ****************************************
  dcrp_state_t r;
  dcrp_state_t n;

  dcrp_cmd_t   op;
  logic [2:0]  init;
  logic        page_out_disable;
  logic        forced_medium_access;
  logic        partial_medium_indicator;
  logic        prev;
  logic        affect;
  logic        other;
  logic        whole;
  logic        ext_any;
  logic        ov1;
  logic        ov2;
  logic        conf;
  logic        bad;
  logic        flush;
  dcrp_mop_t   mop;
  logic [5:0]  act;
  logic        busy;
  logic        fin_good;
  logic        rd_now;
  logic [31:0] rv;

  function automatic logic overlap(input logic [31:0] a, input logic [31:0] c,
                                   input logic [31:0] b, input logic [31:0] l);
    logic [32:0] a_end;
    logic [32:0] b_end;
    a_end = {1'b0, a} + {1'b0, c};
    b_end = {1'b0, b} + {1'b0, l};
    overlap = (c != 32'h0) && (l != 32'h0) && ({1'b0, a} < b_end) && ({1'b0, b} < a_end);
  endfunction : overlap

  // ****************************************
  // Conflict and cache decision
  // ****************************************
  always_comb begin
    op      = dcrp_cmd_t'(r.cmd[CMD_OP_LSB +: 5]);
    init    = r.cmd[CMD_INIT_LSB +: 3];
    page_out_disable         = r.cmd[CMD_KEEP];
    forced_medium_access     = r.cmd[CMD_FORCE];
    partial_medium_indicator = r.cmd[CMD_PART];
    prev    = r.cmd[CMD_PREV];
    affect  = r.cmd[CMD_AFFECT];
    other   = r.resv[RESV_VALID] && (r.resv[RESV_OWN_LSB +: 3] != init);
    whole   = other && !r.resv[RESV_EXT];
    ext_any = other && r.resv[RESV_EXT];
    ov1     = overlap(r.lba, r.cnt, r.extb, r.extl);
    ov2     = overlap(r.lba2, r.cnt, r.extb, r.extl);
    bad     = ({1'b0, r.lba} + {1'b0, r.cnt}) > {1'b0, r.cap};
    flush   = 1'b0;
    mop     = M_NONE;
    // Act: unlock, lock, flush, forced, no_replace, use_cache
    act     = 6'h00;
    conf    = whole;
    case (op)
      C_INQUIRY, C_REQ_SENSE: begin
        conf = 1'b0;
        bad  = 1'b0;
      end
      C_LOG_SEL, C_LOG_SENSE, C_MODE_SENSE, C_TUR,
      C_READ_BUF, C_WRITE_BUF, C_READ_DEF: begin
        bad = 1'b0;
      end
      C_READ_CAP: begin
        conf = whole || (partial_medium_indicator && ext_any && ov1);
        bad  = 1'b0;
      end
      C_FORMAT, C_REZERO, C_START: begin
        conf = whole || ext_any;
        bad  = 1'b0;
      end
      C_PREVENT: begin
        conf = whole || (prev && ext_any);
        bad  = 1'b0;
      end
      C_CHG_DEF: begin
        conf = whole || (ext_any && !r.perinit);
        bad  = 1'b0;
      end
      C_MODE_SEL: begin
        conf = whole || (ext_any && affect && !r.perinit);
        bad  = 1'b0;
      end
      C_SEND_DIAG, C_RECV_DIAG: begin
        conf = whole || (ext_any && affect);
        bad  = 1'b0;
      end
      C_COMPARE, C_COPY, C_COPY_VER: begin
        // Source and destination both count, even on the same unit
        conf = whole || (ext_any && (ov1 || ov2));
        bad  = bad || (({1'b0, r.lba2} + {1'b0, r.cnt}) > {1'b0, r.cap});
      end
      C_READ: begin
        conf = whole || (ext_any && ov1);
        mop  = page_out_disable && forced_medium_access ? M_RD_DIRECT :
               (forced_medium_access ? M_RD_MEDIUM : M_RD_CACHE);
        act  = {3'h0, forced_medium_access, page_out_disable, !forced_medium_access};
      end
      C_WRITE: begin
        conf = whole || (ext_any && ov1);
        mop  = page_out_disable && forced_medium_access ? M_WR_DIRECT :
               (forced_medium_access ? M_WR_THRU : M_WR_BACK);
        act  = {3'h0, forced_medium_access, page_out_disable,
                !(page_out_disable && forced_medium_access)};
      end
      C_VERIFY, C_WR_VERIFY: begin
        conf  = whole || (ext_any && ov1);
        flush = 1'b1;
        mop   = op == C_VERIFY ? M_VERIFY : M_WR_VERIFY;
        act   = {3'h1, 1'b1, page_out_disable, 1'b0};
      end
      C_SYNC: begin
        conf = whole || (ext_any && ov1);
        mop  = M_FLUSH;
        act  = 6'h04;
      end
      C_PREFETCH: begin
        conf = whole || (ext_any && ov1);
        mop  = M_FETCH;
        act  = 6'h01;
      end
      C_LOCK: begin
        conf = whole || (ext_any && ov1);
        mop  = M_LOCK;
        act  = 6'h11;
      end
      C_UNLOCK: begin
        conf = whole || (ext_any && ov1);
        mop  = M_UNLOCK;
        act  = 6'h21;
      end
      C_REASSIGN, C_SET_LIM, C_SEEK: begin
        conf = whole || (ext_any && ov1);
      end
      default: begin
        conf = whole;
      end
    endcase
  end

  // ****************************************
  // Next state: bus, sequencer, flags
  // ****************************************
  always_comb begin
    n        = r;
    busy     = (r.st != ST_IDLE) || r.pend;
    fin_good = 1'b0;
    rd_now   = hsel && htrans[1] && hready && !hwrite;
    rv       = 32'h0;
    n.a_wr   = hsel && htrans[1] && hready && hwrite;
    n.a_addr = haddr[7:0];
    if (r.a_wr) begin
      if (r.a_addr == REG_STAT) begin
        if (hwdata[STAT_DEFER]) begin
          n.deferred = 1'b0;
        end
      end else if (r.a_addr == REG_CTRL) begin
        n.perinit = hwdata[CTRL_PERINIT];
        if (hwdata[CTRL_GO] && !busy) begin
          n.pend = 1'b1;
        end
      end else if (!busy) begin
        // Command fields frozen while busy so decisions stay stable
        if (r.a_addr == REG_CMD) begin
          n.cmd = hwdata;
        end else if (r.a_addr == REG_LBA) begin
          n.lba = hwdata;
        end else if (r.a_addr == REG_CNT) begin
          n.cnt = hwdata;
        end else if (r.a_addr == REG_LBA2) begin
          n.lba2 = hwdata;
        end else if (r.a_addr == REG_RESV) begin
          n.resv = hwdata[4:0];
        end else if (r.a_addr == REG_EXTB) begin
          n.extb = hwdata;
        end else if (r.a_addr == REG_EXTL) begin
          n.extl = hwdata;
        end else if (r.a_addr == REG_CAP) begin
          n.cap = hwdata;
        end
      end
    end
    case (r.st)
      ST_IDLE: begin
        if (r.pend) begin
          n.pend   = 1'b0;
          n.defrep = 1'b0;
          n.mfail  = 1'b0;
          n.act    = act;
          // Decided here, before anything reaches the medium
          if (conf) begin
            n.res = R_CONFLICT;
          end else if (bad) begin
            n.res = R_CHECK;
          end else if (flush) begin
            n.med = '{1'b1, M_FLUSH, page_out_disable, r.lba, r.cnt};
            n.st  = ST_FLUSH;
          end else if (mop != M_NONE) begin
            n.med = '{1'b1, mop, page_out_disable, r.lba, r.cnt};
            n.st  = ST_ACCESS;
          end else begin
            fin_good = 1'b1;
          end
        end
      end
      ST_FLUSH: begin
        if (med_done) begin
          if (med_err) begin
            n.med.valid = 1'b0;
            n.mfail     = 1'b1;
            n.res       = R_CHECK;
            n.st        = ST_IDLE;
          end else begin
            n.med.op = mop;
            n.st     = ST_ACCESS;
          end
        end
      end
      ST_ACCESS: begin
        if (med_done) begin
          n.med.valid = 1'b0;
          n.st        = ST_IDLE;
          if (med_err) begin
            n.mfail = 1'b1;
            n.res   = R_CHECK;
          end else begin
            fin_good = 1'b1;
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    if (fin_good) begin
      // A pending commit error rides on the next clean completion
      if (r.deferred) begin
        n.res      = R_CHECK;
        n.defrep   = 1'b1;
        n.deferred = 1'b0;
      end else begin
        n.res = R_GOOD;
      end
    end
    if (commit_err) begin
      n.deferred = 1'b1;
    end
    // Read data taken from next values so a write just before is seen
    if (rd_now) begin
      if (haddr[7:0] == REG_CMD) begin
        rv = n.cmd;
      end else if (haddr[7:0] == REG_LBA) begin
        rv = n.lba;
      end else if (haddr[7:0] == REG_CNT) begin
        rv = n.cnt;
      end else if (haddr[7:0] == REG_LBA2) begin
        rv = n.lba2;
      end else if (haddr[7:0] == REG_CTRL) begin
        rv[CTRL_PERINIT] = n.perinit;
      end else if (haddr[7:0] == REG_RESV) begin
        rv[4:0] = n.resv;
      end else if (haddr[7:0] == REG_EXTB) begin
        rv = n.extb;
      end else if (haddr[7:0] == REG_EXTL) begin
        rv = n.extl;
      end else if (haddr[7:0] == REG_CAP) begin
        rv = n.cap;
      end else if (haddr[7:0] == REG_STAT) begin
        rv[STAT_BUSY]           = (n.st != ST_IDLE) || n.pend;
        rv[STAT_RES_LSB +: 2]   = n.res;
        rv[STAT_DEFER]          = n.deferred;
        rv[STAT_DEFREP]         = n.defrep;
        rv[STAT_MFAIL]          = n.mfail;
        rv[STAT_ACT_LSB +: 6]   = n.act;
      end
      n.rdata = rv;
    end
    if (!reset_n) begin
      n     = '0;
      n.cap = CAP_RESET;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = r.rdata;
  assign med_req   = r.med;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  wire start = (r.st == ST_IDLE) && r.pend;

  a_conflict_no_med: assert property (
    start && conf |=> r.res == R_CONFLICT && !med_req.valid && r.st == ST_IDLE
  ) else $error("conflict reached the medium");
  a_inquiry_free: assert property (
    start && op == C_INQUIRY |=> r.res != R_CONFLICT
  ) else $error("inquiry saw a conflict");
  a_format_extent: assert property (
    start && op == C_FORMAT && ext_any |=> r.res == R_CONFLICT
  ) else $error("format passed a foreign extent");
  a_tur_extent: assert property (
    start && op == C_TUR && !whole |=> r.res != R_CONFLICT
  ) else $error("test ready blocked by extent");
  a_verify_flush: assert property (
    start && op == C_VERIFY && !conf && !bad
      |=> med_req.valid && med_req.op == M_FLUSH ##1 med_req.valid
  ) else $error("verify did not flush first");
  a_write_thru: assert property (
    start && op == C_WRITE && forced_medium_access && !page_out_disable && !conf && !bad
      |=> med_req.op == M_WR_THRU && r.st == ST_ACCESS
  ) else $error("forced write not through");
  a_read_bypass: assert property (
    start && op == C_READ && forced_medium_access && page_out_disable && !conf && !bad
      |=> med_req.op == M_RD_DIRECT
  ) else $error("read did not bypass cache");
  a_range_check: assert property (
    start && !conf && bad |=> r.res == R_CHECK && !med_req.valid
  ) else $error("out of range not checked");
  a_med_hold: assert property (
    med_req.valid && !med_done && r.st == ST_ACCESS |=> med_req.valid && $stable(med_req.op)
  ) else $error("medium request dropped early");
  a_defer_keep: assert property (
    commit_err |=> r.deferred
  ) else $error("commit error lost");

  c_conflict: cover property (start && conf);
  c_flush_verify: cover property (r.st == ST_FLUSH && med_done ##1 r.st == ST_ACCESS);
  c_defer_report: cover property (r.defrep && r.res == R_CHECK);

endmodule : dcrp_core

// [rtl/dcrp_pkg.sv]
// Package: register map, field layout, enums and carriers of the cache policy block
package dcrp_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] REG_CMD   = 8'h00;
  localparam logic [7:0] REG_LBA   = 8'h04;
  localparam logic [7:0] REG_CNT   = 8'h08;
  localparam logic [7:0] REG_LBA2  = 8'h0c;
  localparam logic [7:0] REG_CTRL  = 8'h10;
  localparam logic [7:0] REG_RESV  = 8'h14;
  localparam logic [7:0] REG_EXTB  = 8'h18;
  localparam logic [7:0] REG_EXTL  = 8'h1c;
  localparam logic [7:0] REG_CAP   = 8'h20;
  localparam logic [7:0] REG_STAT  = 8'h24;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_INIT_LSB = 8;
  localparam int CMD_KEEP     = 16;
  localparam int CMD_FORCE    = 17;
  localparam int CMD_PART     = 18;
  localparam int CMD_PREV     = 19;
  localparam int CMD_AFFECT   = 20;
  localparam int CTRL_GO      = 0;
  localparam int CTRL_PERINIT = 1;
  localparam int RESV_VALID   = 0;
  localparam int RESV_EXT     = 1;
  localparam int RESV_OWN_LSB = 2;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_RES_LSB = 1;
  localparam int STAT_DEFER   = 3;
  localparam int STAT_DEFREP  = 4;
  localparam int STAT_MFAIL   = 5;
  localparam int STAT_ACT_LSB = 6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] CAP_RST = 32'h0001_0000;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [4:0] {
    C_READ = 5'h00, C_WRITE = 5'h01, C_VERIFY = 5'h02, C_WR_VERIFY = 5'h03,
    C_SEEK = 5'h04, C_LOCK = 5'h05, C_UNLOCK = 5'h06, C_PREFETCH = 5'h07,
    C_SYNC = 5'h08, C_COMPARE = 5'h09, C_COPY = 5'h0a, C_COPY_VER = 5'h0b,
    C_REASSIGN = 5'h0c, C_SET_LIM = 5'h0d, C_FORMAT = 5'h0e, C_REZERO = 5'h0f,
    C_START = 5'h10, C_PREVENT = 5'h11, C_CHG_DEF = 5'h12, C_MODE_SEL = 5'h13,
    C_SEND_DIAG = 5'h14, C_RECV_DIAG = 5'h15, C_INQUIRY = 5'h16, C_REQ_SENSE = 5'h17,
    C_LOG_SEL = 5'h18, C_LOG_SENSE = 5'h19, C_MODE_SENSE = 5'h1a, C_TUR = 5'h1b,
    C_READ_BUF = 5'h1c, C_WRITE_BUF = 5'h1d, C_READ_DEF = 5'h1e, C_READ_CAP = 5'h1f
  } dcrp_cmd_t;

  typedef enum logic [1:0] {
    R_GOOD = 2'h0, R_CHECK = 2'h1, R_CONFLICT = 2'h2
  } dcrp_res_t;

  typedef enum logic [3:0] {
    M_NONE = 4'h0, M_RD_CACHE = 4'h1, M_RD_MEDIUM = 4'h2, M_RD_DIRECT = 4'h3,
    M_WR_BACK = 4'h4, M_WR_THRU = 4'h5, M_WR_DIRECT = 4'h6, M_FLUSH = 4'h7,
    M_VERIFY = 4'h8, M_WR_VERIFY = 4'h9, M_FETCH = 4'ha, M_LOCK = 4'hb,
    M_UNLOCK = 4'hc
  } dcrp_mop_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_FLUSH = 2'h1, ST_ACCESS = 2'h2
  } dcrp_st_t;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        valid;
    dcrp_mop_t   op;
    logic        no_replace;
    logic [31:0] lba;
    logic [31:0] cnt;
  } dcrp_med_t;

  typedef struct packed {
    dcrp_st_t    st;
    logic        pend;
    logic [31:0] cmd;
    logic [31:0] lba;
    logic [31:0] cnt;
    logic [31:0] lba2;
    logic        perinit;
    logic [4:0]  resv;
    logic [31:0] extb;
    logic [31:0] extl;
    logic [31:0] cap;
    dcrp_res_t   res;
    logic        deferred;
    logic        defrep;
    logic        mfail;
    logic [5:0]  act;
    dcrp_med_t   med;
    logic [7:0]  a_addr;
    logic        a_wr;
    logic [31:0] rdata;
  } dcrp_state_t;

endpackage : dcrp_pkg

// [testbench/dcrp_med_model.sv]
// Cache and medium engine model that answers the policy block's requests
`timescale 1ns/1ps
module dcrp_med_model (
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  dcrp_pkg::dcrp_med_t med_req,
  input  wire logic [2:0]     delay,
  input  wire logic           fail,
  output logic                med_done,
  output logic                med_err
);
  import dcrp_pkg::*;
  // ****************************************
  // Answer timing
  // ****************************************
  logic [3:0] cnt;
  always_ff @(posedge clk) begin
    if (!reset_n || !med_req.valid || med_done) begin
      cnt      <= 4'h0;
      med_done <= 1'b0;
    end else if (cnt >= {1'b0, delay}) begin
      med_done <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  // Error line only means something with done, so it churns otherwise
  assign med_err = med_done ? fail : cnt[0];
endmodule : dcrp_med_model

// [testbench/tb_disk_cache_reservation_policy.sv]
// Self-checking bench for the cache policy and reservation checker
`timescale 1ns/1ps
module tb_disk_cache_reservation_policy;
  import dcrp_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  localparam logic [31:0] CAP = 32'h0000_0100; // Small capacity keeps ranges short
  logic        clk = 1'b0, reset_n = 1'b0, hwrite = 1'b0, commit_err = 1'b0, fail = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  delay = 3'h1, ro;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, eb, el, l, ra, rn;
  logic        hreadyout, hresp, hready, med_done, med_err, rv, rx, pi, pv;
  logic [4:0]  po, op, ops[$];
  dcrp_med_t   med_req;
  int          err_count = 0, tests_run = 0, seed = 32'h2e94;
  assign hready = hreadyout;
  always #4 clk = ~clk;

  dcrp_core #(.CAP_RESET(CAP)) i_dut (
    .clk(clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .med_req(med_req),
    .med_done(med_done), .med_err(med_err), .commit_err(commit_err));
  dcrp_med_model i_med (.clk(clk), .reset_n(reset_n), .med_req(med_req),
    .delay(delay), .fail(fail), .med_done(med_done), .med_err(med_err));

  // Log of distinct engine requests per command
  always @(posedge clk) begin
    if (med_req.valid === 1'b1 && pv !== 1'b1) begin
      chk(med_req.lba, ra);
      chk(med_req.cnt, rn);
    end
    if (med_req.valid === 1'b1 && (pv !== 1'b1 || po !== {med_req.no_replace, med_req.op})) begin
      ops.push_back({med_req.no_replace, med_req.op});
    end
    pv = med_req.valid;
    po = {med_req.no_replace, med_req.op};
  end
  // ****************************************
  // Tasks and expectations
  // ****************************************
  task automatic conclude;
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // One single-word transfer; read data is taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    q = hrdata;
    if (n >= 100) begin
      err_count++;
      conclude();
    end
  endtask : bus

  task automatic resv(input logic v, input logic x, input logic [2:0] o,
                      input logic [31:0] b, input logic [31:0] n);
    rv = v;
    rx = x;
    ro = o;
    eb = b;
    el = n;
    bus(1'b1, REG_EXTB, b);
    bus(1'b1, REG_EXTL, n);
    bus(1'b1, REG_RESV, {27'h0, o, x, v});
  endtask : resv

  // Flags f: page_out_disable, forced_medium_access, partial_medium, prevent, affects
  task automatic run(input logic [2:0] i, input logic [4:0] c, input logic [4:0] f,
                     input logic [31:0] a, input logic [31:0] n, input logic [31:0] a2);
    int k;
    ops.delete();
    ra = a;
    rn = n;
    bus(1'b1, REG_CMD, {11'h0, f, 5'h0, i, 3'h0, c});
    bus(1'b1, REG_LBA, a);
    bus(1'b1, REG_CNT, n);
    bus(1'b1, REG_LBA2, a2);
    bus(1'b1, REG_CTRL, {30'h0, pi, 1'b1});
    repeat (2) @(posedge clk);
    k = 0;
    do begin
      bus(1'b0, REG_STAT, 32'h0);
      k++;
    end while (q[STAT_BUSY] !== 1'b0 && k < 200);
    if (k >= 200) begin
      err_count++;
      conclude();
    end
  endtask : run

  function automatic logic [1:0] exp_res(input logic [2:0] i, input logic [4:0] c,
      input logic [4:0] f, input logic [31:0] a, input logic [31:0] n, input logic [31:0] a2);
    logic oth, cp, ov, cf;
    oth = rv && ro != i;
    cp  = c == C_COMPARE || c == C_COPY || c == C_COPY_VER;
    ov  = (a < eb + el && eb < a + n) || (cp && a2 < eb + el && eb < a2 + n);
    case (c)
      C_INQUIRY, C_REQ_SENSE: cf = 1'b0;
      C_LOG_SEL, C_LOG_SENSE, C_MODE_SENSE, C_TUR, C_READ_BUF, C_WRITE_BUF,
        C_READ_DEF: cf = oth && !rx;
      C_READ_CAP: cf = oth && (!rx || (f[2] && ov));
      C_FORMAT, C_REZERO, C_START: cf = oth;
      C_PREVENT: cf = oth && (!rx || f[3]);
      C_CHG_DEF: cf = oth && (!rx || !pi);
      C_MODE_SEL: cf = oth && (!rx || (f[4] && !pi));
      C_SEND_DIAG, C_RECV_DIAG: cf = oth && (!rx || f[4]);
      default: cf = oth && (!rx || ov);
    endcase
    if (cf) return R_CONFLICT;
    if (a + n > CAP || (cp && a2 + n > CAP)) return R_CHECK;
    return R_GOOD;
  endfunction : exp_res

  // Run one command and compare its status against the model of the rules
  task automatic cmd(input logic [2:0] i, input logic [4:0] c, input logic [4:0] f,
                     input logic [31:0] a, input logic [31:0] n, input logic [31:0] a2);
    run(i, c, f, a, n, a2);
    chk(q[2:1], exp_res(i, c, f, a, n, a2));
    if (q[2:1] == R_CONFLICT) chk(ops.size(), 0);
  endtask : cmd
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, REG_CAP, 32'h0);
    chk(q, CAP);
    chk({hreadyout, hresp}, 2'b10);
    bus(1'b0, REG_STAT, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 8'h28, 32'hffff_ffff);
    bus(1'b0, 8'h28, 32'h0);
    chk(q, 32'h0);
    pi = 1'b0;
    // Whole-unit reservation held by initiator 1
    resv(1'b1, 1'b0, 3'h1, 32'h0, 32'h0);
    for (int k = 0; k < 32; k++) cmd(3'h2, 5'(k), 5'h0, 32'h0, 32'h1, 32'h0);
    // Extent reservation: every code, flag sets and inside or outside the extent
    resv(1'b1, 1'b1, 3'h1, 32'h10, 32'h10);
    for (int k = 0; k < 128; k++) begin
      l = k[6] ? 32'h40 : 32'h18;
      cmd(3'h2, 5'(k), k[5] ? 5'h1c : 5'h0, l, 32'h1, l);
    end
    pi = 1'b1;
    cmd(3'h2, C_CHG_DEF, 5'h0, 32'h0, 32'h1, 32'h0);
    cmd(3'h2, C_MODE_SEL, 5'h10, 32'h0, 32'h1, 32'h0);
    pi = 1'b0;
    cmd(3'h1, C_WRITE, 5'h0, 32'h18, 32'h2, 32'h0);
    cmd(3'h2, C_COPY, 5'h0, 32'h40, 32'h4, 32'h1e);
    for (int k = 0; k < 60; k++) begin
      delay <= 3'($random(seed));
      op = ($random(seed) & 1) ? C_WRITE : C_READ;
      cmd(3'($random(seed) & 3), op, 5'h0, 32'($unsigned($random(seed)) % 288),
          32'($unsigned($random(seed)) % 16 + 1), 32'h0);
    end
    // Cache replacement and medium access controls, no reservation
    resv(1'b0, 1'b0, 3'h0, 32'h0, 32'h0);
    for (int k = 0; k < 8; k++) begin
      run(3'h0, k[2] ? C_WRITE : C_READ, 5'(k & 3), 32'h0, 32'h4, 32'h0);
      chk(q[2:1], R_GOOD);
      chk(ops.size(), 1);
      chk(ops[0], {k[0], !k[1] ? (k[2] ? M_WR_BACK : M_RD_CACHE) :
          k[0] ? (k[2] ? M_WR_DIRECT : M_RD_DIRECT) : (k[2] ? M_WR_THRU : M_RD_MEDIUM)});
      // Forced reads skip the cache; writes use it unless both bits bypass it
      chk(q[STAT_ACT_LSB +: 6],
          {3'h0, k[1], k[0], k[2] ? !(k[0] && k[1]) : !k[1]});
    end
    for (int k = 0; k < 2; k++) begin
      run(3'h0, k ? C_WR_VERIFY : C_VERIFY, 5'h1, 32'h8, 32'h4, 32'h0);
      chk(ops.size(), 2);
      chk(ops[0][3:0], M_FLUSH);
      chk(ops[1], {1'b1, k ? M_WR_VERIFY : M_VERIFY});
      chk(q[STAT_ACT_LSB +: 6], 6'h0e);
    end
    for (int k = 0; k < 4; k++) begin
      op = k == 0 ? C_LOCK : k == 1 ? C_UNLOCK : k == 2 ? C_PREFETCH : C_SYNC;
      run(3'h0, op, 5'h0, 32'h20, 32'h8, 32'h0);
      chk(ops[0][3:0], k == 0 ? M_LOCK : k == 1 ? M_UNLOCK :
          k == 2 ? M_FETCH : M_FLUSH);
    end
    cmd(3'h0, C_READ, 5'h0, CAP - 1, 32'h1, 32'h0);
    cmd(3'h0, C_READ, 5'h0, CAP - 1, 32'h2, 32'h0);
    chk(ops.size(), 0);
    // Medium failures on sync and on the flush ahead of verify
    fail <= 1'b1;
    run(3'h0, C_SYNC, 5'h0, 32'h0, 32'h4, 32'h0);
    chk(q[2:1], R_CHECK);
    chk(q[STAT_MFAIL], 1'b1);
    run(3'h0, C_VERIFY, 5'h0, 32'h0, 32'h4, 32'h0);
    chk({q[STAT_MFAIL], q[2:1]}, {1'b1, R_CHECK});
    chk(ops.size(), 1);
    fail <= 1'b0;
    // Deferred commit error reported once on the next command
    commit_err <= 1'b1;
    @(posedge clk);
    commit_err <= 1'b0;
    bus(1'b0, REG_STAT, 32'h0);
    chk(q[STAT_DEFER], 1'b1);
    run(3'h0, C_WRITE, 5'h0, 32'h0, 32'h2, 32'h0);
    chk({q[STAT_DEFREP], q[2:1]}, {1'b1, R_CHECK});
    run(3'h0, C_WRITE, 5'h0, 32'h0, 32'h2, 32'h0);
    chk({q[STAT_DEFREP], q[STAT_DEFER], q[2:1]}, {2'b00, R_GOOD});
    commit_err <= 1'b1;
    @(posedge clk);
    commit_err <= 1'b0;
    bus(1'b1, REG_STAT, 32'h8);
    bus(1'b0, REG_STAT, 32'h0);
    chk(q[STAT_DEFER], 1'b0);
    conclude();
  end
endmodule : tb_disk_cache_reservation_policy
